// ==== bench/msps_terms.sv ====
// Terminal-side model: turns level requests from the bench into command pulses.
// Assumes the bench raises a request level right after a rising clock edge.
`timescale 1ns/100ps

module msps_terms
(
   input  wire logic                clk_sys_i,   // System clock
   input  wire logic                nrst_i,      // Async reset, active low
   input  wire msps_pkg::msps_cmd_s req_i,       // Level requests from the bench
   output      msps_pkg::msps_cmd_s cmd_o        // One-cycle command pulses
);
   import msps_pkg::*;

   msps_cmd_s last_reg;                // Request levels seen last cycle

   // Edge detect: a held request gives one pulse, so up/down steps stay countable
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         last_reg <= '0;
         cmd_o    <= '0;
      end
      else
      begin
         last_reg <= req_i;
         cmd_o    <= req_i & ~last_reg;   // Trigger is a pulse
      end
   end
endmodule // msps_terms

// ==== bench/test_multi_speed_program_sequencer.sv ====
// Bench for the speed-program sequencer: APB master, integer expectations.
// Assumes msps_top with TICK_CYC shortened to 4 and the terminal model beside it.
`timescale 1ns/100ps
`include "msps_cfg.svh"

module test_multi_speed_program_sequencer;
   import msps_pkg::*;
   localparam int        TK     = 4;       // Cycles per tenth, shortened
   localparam msps_cmd_s C_RUN  = 7'h40;   // Command patterns
   localparam msps_cmd_s C_STOP = 7'h20;
   localparam msps_cmd_s C_UP   = 7'h04;
   localparam msps_cmd_s C_DN   = 7'h02;
   localparam msps_cmd_s C_DRAW = 7'h01;
   logic          clk_sys_i, nrst_i;       // Clock and reset
   logic          psel, penable, pwrite, pready, pslverr, se;
   logic [7:0]    paddr;                   // APB address
   logic [31:0]   pwdata, prdata, rd;      // Write, read, captured data
   msps_cmd_s     req, cmd;                // Bench levels, model pulses
   logic [2:0]    sel;                     // Preset select terminals
   logic          asg, edir, running, ddone, send, cend;
   logic [1:0]    eramp;                   // Terminal ramp code
   logic [15:0]   mainf, potf;             // Setpoints
   msps_preset_t  pre;                     // Presets 1..7
   msps_timer_t   tmr;                     // Step timers
   msps_drive_s   drv;                     // Drive outputs
   int            err_count, n_checks, k, n, pulses, wraps;
   logic [7:0]    ra [4] = '{`MSPS_A_CTRL, `MSPS_A_DIR, `MSPS_A_RAMP1, `MSPS_A_RAMP2};

   msps_terms term (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req), .cmd_o(cmd));
   msps_top #(.TICK_CYC(TK)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cmd_i(cmd),
      .preset_sel_i(sel), .presets_assigned_i(asg), .ext_ramp_i(eramp),
      .ext_dir_rev_i(edir), .main_setpoint_i(mainf), .pot_setpoint_i(potf),
      .preset_freq_i(pre), .step_timer_i(tmr), .drive_o(drv), .running_o(running),
      .draw_done_o(ddone), .step_end_o(send), .cycle_end_o(cend));

   // 125 MHz clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Value compare, counted
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   // One APB transfer; held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      // Wait states end only with pready; the watchdog catches a hang
      do
      begin
         @(posedge clk_sys_i);
      end while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Raise a request for one cycle, then settle two edges past the pulse
   task automatic pulse(input msps_cmd_s m);
      @(posedge clk_sys_i);
      req <= m;
      @(posedge clk_sys_i);
      req <= '0;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      #(8 * 20000);
      err_count++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      k = $urandom(32'h9eb5cb86);
      {psel, penable, pwrite, paddr, pwdata, req, sel, asg, edir, eramp} = '0;
      err_count = 0;
      n_checks = 0;
      mainf = 16'h1000 + 16'($urandom % 16'h4000);   // Away from the clamps
      potf = 16'($urandom);
      for (int i = 1; i < 8; i++)
         pre[i] = 16'($urandom);
      tmr = '0;
      tmr[0] = 16'h0002;
      tmr[1] = 16'h0003;
      nrst_i = 1'b0;
      repeat (20) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      // Reset values, unmapped access, refused mode code
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset value", 32'h0, rd);
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", 32'h1, {31'h0, se});
      apb(1'b1, `MSPS_A_CTRL, 32'h18);
      apb(1'b0, `MSPS_A_CTRL, 32'h0);
      chk("mode code 6", 32'h0, {29'h0, rd[4:2]});
      // Internal program, one cycle: two used steps, the rest zero time
      apb(1'b1, `MSPS_A_DIR, 32'h0001);
      apb(1'b1, `MSPS_A_RAMP1, 32'h000e);
      apb(1'b1, `MSPS_A_CTRL, 32'h4);
      edir <= 1'b1;
      pulse(C_RUN);
      chk("step1 freq", mainf, drv.freq);
      chk("step1 dir", 32'h1, drv.dir_rev);
      chk("step1 ramp", 32'h2, drv.ramp);
      for (k = 0; send !== 1'b1 && k < 100; k++)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      for (n = 0; n == 0 || (send !== 1'b1 && n < 100); n++)
      begin
         @(posedge clk_sys_i);
         #1;
         if (n == 2)
         begin
            chk("step2 freq", pre[1], drv.freq);
            chk("step2 dir", 32'h0, drv.dir_rev);
            chk("step2 ramp", 32'h3, drv.ramp);
         end
      end
      // The step is left on the clock after its last tenth has run out
      chk("step2 time", 3 * TK + 1, n);
      pulses = 0;
      wraps = 0;
      for (k = 0; k < 60; k++)
      begin
         @(posedge clk_sys_i);
         #1;
         pulses += (send === 1'b1);
         wraps += (cend === 1'b1);
      end
      chk("unused steps", 32'h0, pulses);
      chk("cycle end", 32'h1, wraps);
      chk("one cycle stop", 32'h0, running);
      // External multi-speed: every select code, then unassigned with pot source
      apb(1'b1, `MSPS_A_CTRL, 32'hc);
      asg <= 1'b1;
      pulse(C_RUN);
      for (int c = 0; c < 8; c++)
      begin
         sel <= 3'(c);
         eramp <= 2'(c);
         edir <= c[0];
         repeat (3) @(posedge clk_sys_i);
         #1;
         chk("ext freq", c == 0 ? mainf : pre[c], drv.freq);
         chk("ext ramp dir", {c[1:0], c[0]}, {drv.ramp, drv.dir_rev});
      end
      asg <= 1'b0;
      apb(1'b1, `MSPS_A_CTRL, 32'h8c);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("unassigned", potf, drv.freq);
      pulse(C_STOP);
      // Cycling: auto mode loads with mode 4, then the program keeps running
      apb(1'b1, `MSPS_A_CTRL, 32'h30);
      apb(1'b1, `MSPS_A_CTRL, 32'h4);
      pulse(C_RUN);
      repeat (60) @(posedge clk_sys_i);
      #1;
      chk("cycling", 32'h1, running);
      pulse(C_STOP);
      // Drawing: trigger, ten times timer 1, then hold preset 2
      apb(1'b1, `MSPS_A_CTRL, 32'h10);
      pulse(C_RUN);
      pulse(C_DRAW);
      for (n = 3; ddone !== 1'b1 && n < 200; n++)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      chk("draw time", 32'h1, (n >= 20 * TK && n <= 20 * TK + 4));
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("draw hold", pre[2], drv.freq);
      pulse(C_STOP);
      chk("draw release", 32'h0, {ddone, running});
      // Up/down in normal mode, both step sizes, retain off and on
      apb(1'b1, `MSPS_A_CTRL, 32'h0);
      pulse(C_RUN);
      pulse(C_UP);
      pulse(C_UP);
      chk("up fine", mainf + 16'd2, drv.freq);
      apb(1'b1, `MSPS_A_CTRL, 32'h2);
      pulse(C_DN);
      chk("down coarse", mainf - 16'd8, drv.freq);
      pulse(C_STOP);
      pulse(C_RUN);
      chk("not retained", mainf, drv.freq);
      apb(1'b1, `MSPS_A_CTRL, 32'h3);
      pulse(C_UP);
      pulse(C_STOP);
      pulse(C_RUN);
      chk("retained", mainf + 16'd10, drv.freq);
      pulse(C_STOP);
      // Traverse: jump from preset 7, an up request ignored
      apb(1'b1, `MSPS_A_CTRL, 32'h15);
      pulse(C_RUN);
      chk("trav jump", pre[7], drv.jump);
      pulse(C_UP);
      chk("trav freq", mainf, drv.freq);
      repeat (8) @(posedge clk_sys_i);
      #1;
      chk("trav second", pre[1], drv.freq);
      pulse(C_STOP);
      chk("trav stop", 32'h0, running);
      // A kept trim shows the up request in traverse was ignored
      apb(1'b1, `MSPS_A_CTRL, 32'h1);
      pulse(C_RUN);
      chk("trav up ignored", mainf + 16'd10, drv.freq);
      pulse(C_STOP);
      tally_and_finish();
   end
endmodule // test_multi_speed_program_sequencer

// ==== logic/msps_top.sv ====
// Multi-speed program sequencer: mode select, step timing, preset and setpoint choice.
// Assumes synchronous terminal inputs, one 125 MHz clock and an APB master.
//
// Contract
// - Retain 0 drops up/down changes at stop
// - Up/down step 0.01 Hz or 0.1 Hz
// - Run mode accepts codes 0 to 5
// - Sixteen steps, groups of main plus seven
// - Zero step time marks step unused
// - Internal mode ignores external time and direction
// - Three select inputs pick main or preset
// - Preset select needs assignment and mode 3
// - External mode ramp and direction from terminals
// - Main source 1 means potentiometer setpoint
// - Drawing starts on a terminal trigger
// - Drawing lasts ten times step timer 1
// - After drawing hold preset 2, flag done
// - Traverse accepts only stop, fault, emergency
// - Traverse uses main, preset 1/7, timers 1/2
// - Auto-program mode takes codes 0 to 3
// - Auto mode honoured only with mode 4
// - One-cycle mode stops after last step
// - Cycling repeats, locks out other commands
// - Stop-between-steps pauses after every used step
// - Eight-bit direction mask per group
// - Ramp code 00..11 means sets 1..4
// - Sixteen-bit ramp word, two bits per step
`timescale 1ns/100ps
`include "msps_cfg.svh"

module msps_top #(
   parameter int unsigned TICK_CYC = `MSPS_TICK_CYC   // Cycles per 0.1 s
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  nrst_i,
   // APB slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [7:0]            paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output      logic [31:0]           prdata_o,
   output      logic                  pready_o,
   output      logic                  pslverr_o,
   // Terminal side
   input  wire msps_pkg::msps_cmd_s   cmd_i,
   input  wire logic [2:0]            preset_sel_i,
   input  wire logic                  presets_assigned_i,
   input  wire logic [1:0]            ext_ramp_i,
   input  wire logic                  ext_dir_rev_i,
   // Setpoint tables
   input  wire logic [15:0]           main_setpoint_i,
   input  wire logic [15:0]           pot_setpoint_i,
   input  wire msps_pkg::msps_preset_t preset_freq_i,
   input  wire msps_pkg::msps_timer_t step_timer_i,
   // Drive side
   output      msps_pkg::msps_drive_s drive_o,
   output      logic                  running_o,
   output      logic                  draw_done_o,
   output      logic                  step_end_o,
   output      logic                  cycle_end_o
);
   import msps_pkg::*;

   msps_state_s r_reg;                 // Registered state
   msps_state_s r_next;                // Next state

   logic        tick;                  // One 0.1 s enable pulse
   logic        halt;                  // Stop, fault or emergency stop
   logic        prog;                  // Internal program mode
   logic        locked;                // Only halt commands accepted
   logic        setup;                 // APB setup phase
   logic        acc;                   // APB access phase
   logic        mapped;                // Address decodes
   logic [15:0] cur_time;              // Current step time, tenths
   logic [15:0] base;                  // Selected main setpoint
   logic [15:0] adj;                   // Main plus up/down offset
   logic [18:0] ud_sum;                // Up/down trial sum
   logic [2:0]  wmode;                 // Written run mode

   // Shared decodes
   always_comb
   begin
      tick     = (r_reg.tick == 24'(TICK_CYC - 1));
      halt     = cmd_i.stop | cmd_i.fault | cmd_i.estop;
      prog     = (r_reg.mode == `MSPS_M_INTERNAL);
      // Traverse and cycling runs accept nothing but halt
      locked   = (r_reg.st != MSPS_IDLE) &&
                 ((r_reg.mode == `MSPS_M_TRAV) || (prog && r_reg.auto[0]));
      setup    = psel_i & ~penable_i;
      acc      = psel_i & penable_i;
      mapped   = (paddr_i == `MSPS_A_CTRL) || (paddr_i == `MSPS_A_DIR) ||
                 (paddr_i == `MSPS_A_RAMP1) || (paddr_i == `MSPS_A_RAMP2) ||
                 (paddr_i == `MSPS_A_STAT) || (paddr_i == `MSPS_A_FREQ);
      cur_time = step_timer_i[r_reg.step];
      // Potentiometer or stored digital setpoint
      base     = r_reg.msrc ? pot_setpoint_i : main_setpoint_i;
      // Sign-extend the trim so a negative offset lowers the setpoint
      ud_sum   = {r_reg.ud_off[17], r_reg.ud_off} + {3'b000, base};
      // Clamp the adjusted setpoint into 0..ffff
      if (ud_sum[18])
         adj = 16'h0000;
      else if (ud_sum[17:16] != 2'b00)
         adj = 16'hffff;
      else
         adj = ud_sum[15:0];
      wmode    = pwdata_i[`MSPS_F_MODE_LO +: 3];
   end

   // APB answers in the access cycle; no wait states
   assign pready_o  = acc;
   assign pslverr_o = acc & ~mapped;
   assign prdata_o  = r_reg.prdata;

   assign drive_o     = r_reg.drv;
   assign running_o   = (r_reg.st != MSPS_IDLE);
   assign draw_done_o = r_reg.done;
   assign step_end_o  = r_reg.step_end;
   assign cycle_end_o = r_reg.cyc_end;

   // Next-state logic of the whole block
   always_comb
   begin
      logic [17:0] stepv;              // Up/down step size
      logic [18:0] trial;              // Offset after one step
      logic        adv;                // Leave current step
      logic        skip;               // Step unused
      adv   = 1'b0;
      skip  = 1'b0;
      stepv = 18'h00000;
      trial = 19'h00000;
      r_next = r_reg;
      r_next.step_end = 1'b0;
      r_next.cyc_end  = 1'b0;

      // Tenth-of-second divider, restarted at every step entry
      r_next.tick = tick ? 24'h000000 : r_reg.tick + 24'h000001;
      if (tick)
         r_next.tenths = r_reg.tenths + 20'h00001;

      // Register writes take effect in the access phase
      if (acc & pwrite_i)
      begin
         unique case (paddr_i)
            `MSPS_A_CTRL:
            begin
               r_next.retain = pwdata_i[`MSPS_F_RETAIN];
               r_next.ustep  = pwdata_i[`MSPS_F_USTEP];
               r_next.msrc   = pwdata_i[`MSPS_F_MSRC];
               // Codes 6 and 7 are refused; mode stays
               if (wmode <= `MSPS_M_TRAV)
                  r_next.mode = wmode;
               // Auto field only loads alongside mode 4
               if (wmode == `MSPS_M_DRAW)
                  r_next.auto = pwdata_i[`MSPS_F_AUTO_LO +: 2];
            end
            `MSPS_A_DIR:   r_next.dmask = pwdata_i[15:0];
            `MSPS_A_RAMP1: r_next.ramp1 = pwdata_i[15:0];
            `MSPS_A_RAMP2: r_next.ramp2 = pwdata_i[15:0];
            default:       r_next.dmask = r_reg.dmask;
         endcase
      end

      // Read data is captured in the setup phase
      if (setup)
      begin
         unique case (paddr_i)
            `MSPS_A_CTRL:  r_next.prdata = {24'h000000, r_reg.msrc, r_reg.auto,
                                            r_reg.mode, r_reg.ustep, r_reg.retain};
            `MSPS_A_DIR:   r_next.prdata = {16'h0000, r_reg.dmask};
            `MSPS_A_RAMP1: r_next.prdata = {16'h0000, r_reg.ramp1};
            `MSPS_A_RAMP2: r_next.prdata = {16'h0000, r_reg.ramp2};
            `MSPS_A_STAT:  r_next.prdata = {16'h0000, r_reg.done, 3'h0,
                                            r_reg.st, r_reg.drv.ramp,
                                            r_reg.drv.dir_rev, r_reg.step};
            `MSPS_A_FREQ:  r_next.prdata = {16'h0000, r_reg.drv.freq};
            default:       r_next.prdata = 32'h00000000;
         endcase
      end

      // Up/down trims the setpoint in normal running only
      stepv = r_reg.ustep ? `MSPS_UD_COARSE : `MSPS_UD_FINE;
      trial = cmd_i.up ? {r_reg.ud_off[17], r_reg.ud_off} + {1'b0, stepv}
                       : {r_reg.ud_off[17], r_reg.ud_off} - {1'b0, stepv};
      if ((r_reg.st == MSPS_RUN) && !locked && (cmd_i.up ^ cmd_i.down) &&
          (r_reg.mode == `MSPS_M_NORMAL) &&
          ($signed(trial) <= $signed({1'b0, `MSPS_UD_LIMIT})) &&
          ($signed(trial) >= -$signed({1'b0, `MSPS_UD_LIMIT})))
         r_next.ud_off = trial[17:0];

      // Sequencer
      unique case (r_reg.st)
         MSPS_IDLE:
         begin
            // Run command starts at step 1 with a fresh timer
            if (cmd_i.run && !halt)
            begin
               r_next.st     = MSPS_RUN;
               r_next.step   = 4'h0;
               r_next.scan   = 5'h00;
               r_next.tick   = 24'h000000;
               r_next.tenths = 20'h00000;
            end
         end
         MSPS_RUN:
         begin
            if (prog)
            begin
               // Unused steps are passed one per cycle
               skip = (cur_time == 16'h0000);
               adv  = skip || (r_reg.tenths >= {4'h0, cur_time});
            end
            else if (r_reg.mode == `MSPS_M_TRAV)
            begin
               // Rising segment on timer 1, falling on timer 2
               if (r_reg.tenths >= {4'h0, step_timer_i[r_reg.step[0]]})
               begin
                  r_next.step   = {3'h0, ~r_reg.step[0]};
                  r_next.tenths = 20'h00000;
                  r_next.tick   = 24'h000000;
               end
            end
            else if ((r_reg.mode == `MSPS_M_DRAW) && cmd_i.draw_trig)
            begin
               r_next.st     = MSPS_DRAW;
               r_next.tenths = 20'h00000;
               r_next.tick   = 24'h000000;
            end
         end
         MSPS_PAUSE:
         begin
            // One tick at zero between steps, then restart
            if (tick)
            begin
               r_next.st     = MSPS_RUN;
               r_next.tenths = 20'h00000;
            end
         end
         MSPS_DRAW:
         begin
            if (r_reg.tenths >= 20'(step_timer_i[0]) * `MSPS_DRAW_MULT)
            begin
               r_next.st   = MSPS_HOLD;
               r_next.done = 1'b1;
            end
         end
         MSPS_HOLD:
            r_next.done = 1'b1;
      endcase

      // Leaving a step: wrap, end of cycle, optional pause
      if (adv)
      begin
         r_next.step   = r_reg.step + 4'h1;
         r_next.tenths = 20'h00000;
         r_next.tick   = 24'h000000;
         r_next.scan   = skip ? r_reg.scan + 5'h01 : 5'h00;
         r_next.step_end = ~skip;
         if (r_reg.step == 4'hf)
            r_next.cyc_end = 1'b1;
         // One-cycle modes end at the wrap
         if ((r_reg.step == 4'hf) && !r_reg.auto[0])
            r_next.st = MSPS_IDLE;
         else if (skip && (r_reg.scan == 5'h0f))
            r_next.st = MSPS_IDLE;     // Every step unused: nothing to cycle
         else if (!skip && r_reg.auto[1])
            r_next.st = MSPS_PAUSE;
      end

      // Halt always wins; a retain of 0 drops the trim
      if (halt && (r_reg.st != MSPS_IDLE))
      begin
         r_next.st   = MSPS_IDLE;
         r_next.done = 1'b0;
         if (!r_reg.retain)
            r_next.ud_off = 18'h00000;
      end

      // Drive outputs, chosen from the present state
      r_next.drv.jump    = 16'h0000;
      r_next.drv.dir_rev = ext_dir_rev_i;
      r_next.drv.ramp    = ext_ramp_i;
      unique case (r_reg.st)
         MSPS_IDLE, MSPS_PAUSE:
            r_next.drv.freq = 16'h0000;
         MSPS_DRAW:
            r_next.drv.freq = base;
         MSPS_HOLD:
            r_next.drv.freq = preset_freq_i[2];
         MSPS_RUN:
         begin
            unique case (r_reg.mode)
               `MSPS_M_INTERNAL:
               begin
                  // Step 1 of a group is the main setpoint
                  r_next.drv.freq = (r_reg.step[2:0] == 3'h0) ? base
                                    : preset_freq_i[r_reg.step[2:0]];
                  // Terminals ignored: mask and ramp word rule
                  r_next.drv.dir_rev = r_reg.dmask[{r_reg.step[3], r_reg.step[2:0]}];
                  r_next.drv.ramp = r_reg.step[3]
                                    ? r_reg.ramp2[{r_reg.step[2:0], 1'b0} +: 2]
                                    : r_reg.ramp1[{r_reg.step[2:0], 1'b0} +: 2];
               end
               `MSPS_M_EXTMS:
               begin
                  if (presets_assigned_i && (preset_sel_i != 3'h0))
                     r_next.drv.freq = preset_freq_i[preset_sel_i];
                  else
                     r_next.drv.freq = base;
               end
               `MSPS_M_TRAV:
               begin
                  r_next.drv.freq    = r_reg.step[0] ? preset_freq_i[1] : base;
                  r_next.drv.jump    = preset_freq_i[7];
                  r_next.drv.dir_rev = 1'b0;
                  r_next.drv.ramp    = 2'h0;
               end
               `MSPS_M_DRAW:
                  r_next.drv.freq = base;
               default:
                  r_next.drv.freq = adj;
            endcase
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r_reg        <= '0;
         r_reg.st     <= MSPS_IDLE;
         r_reg.mode   <= `MSPS_RST_MODE;
         r_reg.auto   <= `MSPS_RST_AUTO;
         r_reg.dmask  <= `MSPS_RST_MASK;
         r_reg.ramp1  <= `MSPS_RST_RAMP;
         r_reg.ramp2  <= `MSPS_RST_RAMP;
      end
      else
         r_reg <= r_next;
   end

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence s_halt;
      cmd_i.stop || cmd_i.fault || cmd_i.estop;
   endsequence

   sequence s_run_prog;
      (r_reg.st == MSPS_RUN) && prog && !halt;
   endsequence

   a_halt_stops: assert property (s_halt |=> !running_o ##1 drive_o.freq == 16'h0000)
      else $error("halt did not stop the sequencer");

   a_trav_locked: assert property (locked && !halt |=> $stable(r_reg.ud_off))
      else $error("trim changed in a locked run");

   a_ud_fine: assert property ((r_reg.st == MSPS_RUN) && !locked && !halt &&
         (r_reg.mode == `MSPS_M_NORMAL) && !r_reg.ustep && cmd_i.up && !cmd_i.down &&
         ($signed(r_reg.ud_off) < 18'sh0fff0)
         |=> r_reg.ud_off == $past(r_reg.ud_off) + 18'h00001)
      else $error("fine up step wrong");

   a_drop_trim: assert property (s_halt ##0 (running_o && !r_reg.retain)
         |=> r_reg.ud_off == 18'h00000)
      else $error("trim kept at stop");

   a_ext_preset: assert property ((r_reg.st == MSPS_RUN) && !halt &&
         (r_reg.mode == `MSPS_M_EXTMS) && presets_assigned_i && (preset_sel_i == 3'h5)
         |=> drive_o.freq == $past(preset_freq_i[5]))
      else $error("preset select wrong");

   a_zero_skip: assert property (s_run_prog ##0 (cur_time == 16'h0000)
         |=> r_reg.step == $past(r_reg.step) + 4'h1)
      else $error("unused step not skipped");

   a_hold_preset: assert property ((r_reg.st == MSPS_HOLD) && !halt
         |=> draw_done_o && drive_o.freq == $past(preset_freq_i[2]))
      else $error("hold output wrong");

   a_dir_mask: assert property (s_run_prog
         |=> drive_o.dir_rev == $past(r_reg.dmask[r_reg.step]))
      else $error("direction mask not applied");

   a_ramp_word: assert property (s_run_prog ##0 (r_reg.step == 4'h2)
         |=> drive_o.ramp == $past(r_reg.ramp1[5:4]))
      else $error("ramp code not applied");

endmodule // msps_top

// ==== pkg/msps_cfg.svh ====
// Constants of the multi-speed program sequencer: offsets, fields, resets, timing.
// Assumes a 125 MHz system clock and a byte-addressed APB with 32-bit data.
`ifndef MSPS_CFG_SVH
`define MSPS_CFG_SVH

// Register byte offsets
`define MSPS_A_CTRL        8'h00
`define MSPS_A_DIR         8'h04
`define MSPS_A_RAMP1       8'h08
`define MSPS_A_RAMP2       8'h0c
`define MSPS_A_STAT        8'h10
`define MSPS_A_FREQ        8'h14

// Control register fields
`define MSPS_F_RETAIN      0
`define MSPS_F_USTEP       1
`define MSPS_F_MODE_LO     2
`define MSPS_F_AUTO_LO     5
`define MSPS_F_MSRC        7

// Run-mode codes
`define MSPS_M_NORMAL      3'h0
`define MSPS_M_INTERNAL    3'h1
`define MSPS_M_EXT4        3'h2
`define MSPS_M_EXTMS       3'h3
`define MSPS_M_DRAW        3'h4
`define MSPS_M_TRAV        3'h5

// Reset values
`define MSPS_RST_MODE      3'h0
`define MSPS_RST_AUTO      2'h0
`define MSPS_RST_MASK      16'h0000
`define MSPS_RST_RAMP      16'h0000

// Up/down step sizes in 0.01 Hz units
`define MSPS_UD_FINE       18'h00001
`define MSPS_UD_COARSE     18'h0000a
`define MSPS_UD_LIMIT      18'h0ffff

// Step timer unit and clock rate
`define MSPS_TICK_MS       100
`define MSPS_CLK_KHZ       125000
`define MSPS_TICK_CYC      (`MSPS_TICK_MS * `MSPS_CLK_KHZ)
`define MSPS_DRAW_MULT     20'd10

`endif

// ==== pkg/msps_pkg.sv ====
// Types of the multi-speed program sequencer.
// Constants live in msps_cfg.svh; this package holds only types.
package msps_pkg;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      MSPS_IDLE  = 5'h01,
      MSPS_RUN   = 5'h02,
      MSPS_PAUSE = 5'h04,
      MSPS_DRAW  = 5'h08,
      MSPS_HOLD  = 5'h10
   } msps_state_e;

   typedef logic [7:1][15:0]  msps_preset_t;   // Presets 1..7, 0.01 Hz
   typedef logic [15:0][15:0] msps_timer_t;    // Step timers 1..16, 0.1 s

   // Commands from the terminal side
   typedef struct packed {
      logic run;
      logic stop;
      logic fault;
      logic estop;
      logic up;
      logic down;
      logic draw_trig;
   } msps_cmd_s;

   // Drive outputs toward the ramp generator
   typedef struct packed {
      logic [15:0] freq;
      logic        dir_rev;
      logic [1:0]  ramp;
      logic [15:0] jump;
   } msps_drive_s;

   // Whole state of the block
   typedef struct packed {
      msps_state_e st;
      logic [3:0]  step;
      logic [4:0]  scan;
      logic [23:0] tick;
      logic [19:0] tenths;
      logic [17:0] ud_off;
      logic        retain;
      logic        ustep;
      logic [2:0]  mode;
      logic [1:0]  auto;
      logic        msrc;
      logic [15:0] dmask;
      logic [15:0] ramp1;
      logic [15:0] ramp2;
      msps_drive_s drv;
      logic        done;
      logic        step_end;
      logic        cyc_end;
      logic [31:0] prdata;
   } msps_state_s;

endpackage
